// *** core/nad_pkg.sv ***
// package for the nibble add execution block
package nad_pkg;
  localparam int NAD_DW = 4;
  localparam int NAD_AW = 7;
  localparam int NAD_WW = 4;
  // opcode high byte values; memory forms decode on byte plus bit 7
  localparam logic [7:0] OP_ADC_WR_WB = 8'h0d;
  localparam logic [7:0] OP_ADD_MEM = 8'h18;
  localparam logic [7:0] OP_ADD_MEM_WB = 8'h19;
  localparam logic [7:0] OP_ADD_WR = 8'h1c;
  localparam logic [7:0] OP_ADD_WR_WB = 8'h1d;
  localparam logic [7:0] OP_KEEP_CARRY_MEM = 8'h28;
  localparam logic [7:0] OP_KEEP_CARRY_MEM_WB = 8'h29;
  localparam logic [7:0] OP_KEEP_CARRY_WR = 8'h2c;
  localparam logic [7:0] OP_KEEP_CARRY_WR_WB = 8'h2d;
  localparam logic [3:0] NAD_ACCUM_RST = 4'h0;
  localparam logic NAD_CARRY_RST = 1'b0;
  localparam logic NAD_ZERO_RST = 1'b0;

  // operand source and destination decoded from an instruction
  typedef struct packed {
    logic valid;
    logic use_mem;
    logic use_cin;
    logic wr_back;
    logic upd_carry;
  } nad_dec_s;

  // write-back request toward data memory or working register file
  typedef struct packed {
    logic mem_we;
    logic [6:0] mem_addr;
    logic wr_we;
    logic [3:0] wr_sel;
    logic [3:0] data;
  } nad_wb_s;
endpackage : nad_pkg

// *** core/nad_add_unit.sv ***
// nibble add instruction execution: accumulator, flags and write-back
`timescale 1ns/1ps
module nad_add_unit
  import nad_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic exec,
  input wire logic [15:0] instr,
  input wire logic [3:0] mem_rd_data,
  input wire logic [3:0] wr_rd_data,
  output logic [3:0] result_nibble_register,
  output logic carry_bit,
  output logic zero_bit,
  output nad_wb_s wb_ff,
  output logic done_ff
);
  nad_dec_s dec;
  logic [3:0] opnd_a;
  logic [3:0] imm;
  logic [4:0] sum;
  logic [3:0] accum_ff;
  logic carry_ff;
  logic zero_ff;

  assign imm = instr[7:4];

  // decode the high byte; memory forms need bit 7 clear
  always_comb
  begin
    dec = '0;
    unique case (instr[15:8])
      OP_ADC_WR_WB: dec = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      OP_ADD_MEM: dec = '{~instr[7], 1'b1, 1'b0, 1'b0, 1'b1};
      OP_ADD_WR: dec = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      OP_ADD_MEM_WB: dec = '{~instr[7], 1'b1, 1'b0, 1'b1, 1'b1};
      OP_ADD_WR_WB: dec = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
      OP_KEEP_CARRY_MEM: dec = '{~instr[7], 1'b1, 1'b0, 1'b0, 1'b0};
      OP_KEEP_CARRY_WR: dec = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_KEEP_CARRY_MEM_WB: dec = '{~instr[7], 1'b1, 1'b0, 1'b1, 1'b0};
      OP_KEEP_CARRY_WR_WB: dec = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      default: dec = '0;
    endcase
  end

  // memory forms add memory to accumulator, register forms add immediate
  assign opnd_a = dec.use_mem ? accum_ff : imm;
  assign sum = {1'b0, dec.use_mem ? mem_rd_data : wr_rd_data} + {1'b0, opnd_a}
    + {4'h0, dec.use_cin & carry_ff};

  // accumulator load in one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      accum_ff <= NAD_ACCUM_RST;
    else if (clk_en && exec && dec.valid)
      accum_ff <= sum[3:0];
  end

  // carry follows carry-out unless the keep-carry forms run
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      carry_ff <= NAD_CARRY_RST;
    else if (clk_en && exec && dec.valid && dec.upd_carry)
      carry_ff <= sum[4];
  end

  // zero flag updated by every add form
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      zero_ff <= NAD_ZERO_RST;
    else if (clk_en && exec && dec.valid)
      zero_ff <= (sum[3:0] == 4'h0);
  end

  // write-back strobe to memory or working register, one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wb_ff <= '0;
      done_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      done_ff <= exec && dec.valid;
      wb_ff.mem_we <= exec && dec.valid && dec.wr_back && dec.use_mem;
      wb_ff.wr_we <= exec && dec.valid && dec.wr_back && !dec.use_mem;
      wb_ff.mem_addr <= instr[6:0];
      wb_ff.wr_sel <= instr[3:0];
      wb_ff.data <= sum[3:0];
    end
  end

  assign result_nibble_register = accum_ff;
  assign carry_bit = carry_ff;
  assign zero_bit = zero_ff;

  // helper: an accepted instruction this cycle
  logic go;
  assign go = clk_en && exec && dec.valid;

  sequence s_go_keep;
    go && !dec.upd_carry;
  endsequence

  property p_keep_carry;
    @(posedge sys_clk) disable iff (!rst_n)
    s_go_keep |=> $stable(carry_ff);
  endproperty
  a_keep_carry: assert property (p_keep_carry) else $error("carry changed");

  property p_carry_out;
    @(posedge sys_clk) disable iff (!rst_n)
    go && dec.upd_carry |=> carry_ff == $past(sum[4]);
  endproperty
  a_carry_out: assert property (p_carry_out) else $error("carry wrong");

  property p_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    go |=> zero_ff == (accum_ff == 4'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_mem_wb;
    @(posedge sys_clk) disable iff (!rst_n)
    go && dec.wr_back && dec.use_mem |=> wb_ff.mem_we && wb_ff.data == accum_ff;
  endproperty
  a_mem_wb: assert property (p_mem_wb) else $error("memory write-back missing");

  property p_wr_wb;
    @(posedge sys_clk) disable iff (!rst_n)
    go && dec.wr_back && !dec.use_mem |=> wb_ff.wr_we && wb_ff.data == accum_ff;
  endproperty
  a_wr_wb: assert property (p_wr_wb) else $error("register write-back missing");

  property p_no_wb;
    @(posedge sys_clk) disable iff (!rst_n)
    go && !dec.wr_back |=> !wb_ff.mem_we && !wb_ff.wr_we;
  endproperty
  a_no_wb: assert property (p_no_wb) else $error("spurious write-back");

  property p_cin;
    @(posedge sys_clk) disable iff (!rst_n)
    go && instr[15:8] == OP_ADC_WR_WB
      |=> accum_ff == 4'(($past(wr_rd_data) + $past(imm)) + {3'h0, $past(carry_ff)});
  endproperty
  a_cin: assert property (p_cin) else $error("carry-in sum wrong");

  property p_imm_add;
    @(posedge sys_clk) disable iff (!rst_n)
    go && instr[15:8] == OP_ADD_WR |=> accum_ff == 4'($past(wr_rd_data) + $past(imm));
  endproperty
  a_imm_add: assert property (p_imm_add) else $error("immediate sum wrong");

  property p_done;
    @(posedge sys_clk) disable iff (!rst_n)
    go |=> done_ff;
  endproperty
  a_done: assert property (p_done) else $error("not one cycle");

  // a low clock enable freezes every register
  sequence s_frozen;
    !clk_en;
  endsequence

  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
    s_frozen |=> $stable(accum_ff) && $stable(carry_ff) && $stable(zero_ff) && $stable(done_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  // an unknown opcode or a memory form with bit 7 set leaves accumulator and flags alone and raises no strobe
  sequence s_refused;
    clk_en && exec && !dec.valid;
  endsequence

  property p_refused;
    @(posedge sys_clk) disable iff (!rst_n)
    s_refused |=> !done_ff && !wb_ff.mem_we && !wb_ff.wr_we && $stable(accum_ff)
      && $stable(carry_ff) && $stable(zero_ff);
  endproperty
  a_refused: assert property (p_refused) else $error("refused opcode took effect");

  // memory forms add the addressed nibble to the old accumulator
  sequence s_go_mem;
    go && dec.use_mem;
  endsequence

  property p_mem_sum;
    @(posedge sys_clk) disable iff (!rst_n)
    s_go_mem |=> accum_ff == 4'($past(mem_rd_data) + $past(accum_ff));
  endproperty
  a_mem_sum: assert property (p_mem_sum) else $error("memory sum wrong");

  property p_wb_loc;
    @(posedge sys_clk) disable iff (!rst_n)
    s_go_mem |=> wb_ff.mem_addr == $past(instr[6:0]);
  endproperty
  a_wb_loc: assert property (p_wb_loc) else $error("write-back address wrong");

  // strobes drop again after one enabled idle cycle
  sequence s_go_then_idle;
    go ##1 (clk_en && !exec);
  endsequence

  property p_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
    s_go_then_idle |=> !done_ff && !wb_ff.mem_we && !wb_ff.wr_we;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse held too long");

  // keep-carry register forms: plain sum, carry untouched
  sequence s_go_keep_wr;
    go && !dec.upd_carry && !dec.use_mem;
  endsequence

  property p_keep_wr_sum;
    @(posedge sys_clk) disable iff (!rst_n)
    s_go_keep_wr |=> accum_ff == 4'($past(wr_rd_data) + $past(imm)) && $stable(carry_ff);
  endproperty
  a_keep_wr_sum: assert property (p_keep_wr_sum) else $error("keep-carry sum wrong");

  property p_add_wb_sum;
    @(posedge sys_clk) disable iff (!rst_n)
    go && instr[15:8] == OP_ADD_WR_WB |=> wb_ff.data == 4'($past(wr_rd_data) + $past(imm));
  endproperty
  a_add_wb_sum: assert property (p_add_wb_sum) else $error("write-back sum wrong");
endmodule : nad_add_unit

// *** verif/test_nibble_add_instructions.sv ***
// self-checking bench for the nibble add execution block
`timescale 1ns/1ps
module test_nibble_add_instructions;
  import nad_pkg::*;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic clk_en = 1;
  logic exec = 0;
  logic [15:0] instr = '0;
  logic [3:0] mem_rd_data = '0;
  logic [3:0] wr_rd_data = '0;
  logic [3:0] accum;
  logic cy;
  logic zr;
  logic done;
  nad_wb_s wb;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h5337c7d1;
  logic [3:0] accum_m = '0;
  logic cy_m = 0;
  logic zr_m = 0;
  logic [7:0] ops [9] = '{OP_ADC_WR_WB, OP_ADD_MEM, OP_ADD_MEM_WB, OP_ADD_WR, OP_ADD_WR_WB,
    OP_KEEP_CARRY_MEM, OP_KEEP_CARRY_MEM_WB, OP_KEEP_CARRY_WR, OP_KEEP_CARRY_WR_WB};
  // clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      print_verdict();
    end
  end
  nad_add_unit uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .exec(exec),
    .instr(instr), .mem_rd_data(mem_rd_data), .wr_rd_data(wr_rd_data),
    .result_nibble_register(accum), .carry_bit(cy), .zero_bit(zr), .wb_ff(wb), .done_ff(done));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // expected 5-bit sum from the operands and the model state
  function automatic logic [4:0] sum_of(input logic [7:0] op, input logic [7:0] lo,
    input logic [3:0] m, input logic [3:0] w);
    if (op[3:0] inside {4'h8, 4'h9})
      return m + accum_m;
    return w + lo[7:4] + ((op == OP_ADC_WR_WB) ? cy_m : 1'b0);
  endfunction : sum_of
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one instruction: drive, let it be taken, then compare on the falling edge half a cycle later
  task automatic run_op(input logic [7:0] op, input logic [7:0] lo, input logic en);
    logic mem;
    logic ok;
    logic [4:0] s;
    seed = xs(seed);
    mem = op[3:0] inside {4'h8, 4'h9};
    ok = en && (op inside {ops}) && !(mem && lo[7]);
    s = sum_of(op, lo, seed[3:0], seed[7:4]);
    @(posedge sys_clk);
    instr <= {op, lo};
    exec <= 1;
    clk_en <= en;
    mem_rd_data <= seed[3:0];
    wr_rd_data <= seed[7:4];
    @(posedge sys_clk);
    exec <= 0;
    clk_en <= 1;
    @(negedge sys_clk);
    if (ok)
    begin
      accum_m = s[3:0];
      zr_m = (s[3:0] == 4'h0);
      if (op[7:4] < 4'h2)
        cy_m = s[4];
    end
    chk("accum", accum, accum_m);
    chk("carry", cy, cy_m);
    chk("zero", zr, zr_m);
    chk("done", done, ok);
    chk("mem_we", wb.mem_we, ok && mem && op[0]);
    chk("wr_we", wb.wr_we, ok && !mem && op[0]);
    if (ok && op[0])
    begin
      chk("wb_data", wb.data, s[3:0]);
      chk("wb_loc", mem ? wb.mem_addr : wb.wr_sel, mem ? lo[6:0] : lo[3:0]);
    end
  endtask : run_op
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // reset, corner cases, then random traffic
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1;
    @(negedge sys_clk);
    chk("reset", {done, zr, cy, accum}, 8'h00);
    chk("reset_wb", {wb.mem_we, wb.wr_we}, 8'h00);
    foreach (ops[i])
    begin
      run_op(ops[i], 8'h7f, 1);
      run_op(ops[i], 8'h0f, 1);
    end
    run_op(8'h1e, 8'h12, 1);
    run_op(OP_ADD_MEM, 8'h85, 1);
    run_op(OP_ADD_WR, 8'hf1, 0);
    $display("test corner done");
    repeat (300)
    begin
      seed = xs(seed);
      run_op(seed[23:21] == 0 ? seed[31:24] : ops[seed[3:0] % 9], seed[15:8], seed[20:18] != 0);
    end
    $display("test random done");
    print_verdict();
  end
endmodule : test_nibble_add_instructions
